// file: rtsr_host_model.sv
// ahb-lite host model issuing single word transfers
`timescale 1ns/10ps
`default_nettype none
module rtsr_host_model
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        req,
  input  wire logic [31:0] addr,
  input  wire logic        wr,
  input  wire logic [31:0] wdata,
  input  wire logic [31:0] hrdata,
  input  wire logic        hready,
  output logic      [31:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata,
  output logic      [31:0] rdata,
  output logic             done
);
  logic        dph_q;
  logic [31:0] wd_q;
  assign hsize = 3'h2;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      {haddr, htrans, hwrite, hwdata, rdata, done, dph_q, wd_q} <= '0;
    end
    else
    begin
      done <= 1'h0;
      if (htrans[1] && hready)
      begin
        htrans <= 2'h0;
        dph_q  <= 1'h1;
        hwdata <= wd_q;
      end
      else if (dph_q && hready)
      begin
        dph_q  <= 1'h0;
        done   <= 1'h1;
        rdata  <= hrdata;
        // released data lines are driven with the inverse of the last value
        hwdata <= ~hwdata;
      end
      else if (req)
      begin
        htrans <= 2'h2;
        haddr  <= addr;
        hwrite <= wr;
        wd_q   <= wdata;
      end
    end
  end
endmodule // rtsr_host_model
`default_nettype wire

// file: rtsr_mem.sv
// small queue storage with registered read data
`timescale 1ns/10ps
`default_nettype none
module rtsr_mem
  import rtsr_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                ce,
  input  wire logic                we,
  input  wire logic [rtsr_pkg::RTSR_AW-1:0] waddr,
  input  wire logic [3:0]          wdata,
  input  wire logic [rtsr_pkg::RTSR_AW-1:0] raddr,
  output logic      [3:0]          rdata
);
  logic [3:0] mem_q [RTSR_DEPTH];

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (we)
        mem_q[waddr] <= wdata;
      // a word written to the slot being read is passed straight through
      if (we && waddr == raddr)
        rdata <= wdata;
      else
        rdata <= mem_q[raddr];
    end
  end
endmodule // rtsr_mem
`default_nettype wire

// file: rtsr_pkg.sv
// shared constants and types for the rotary touch status registers
package rtsr_pkg;

  localparam logic [31:0] RTSR_OFS_QUEUE = 32'h0000_0000;
  localparam logic [31:0] RTSR_OFS_FAULT = 32'h0000_0004;
  localparam logic [31:0] RTSR_OFS_LIVE  = 32'h0000_0008;
  localparam logic [31:0] RTSR_OFS_IRQST = 32'h0000_000C;
  localparam logic [31:0] RTSR_OFS_IRQMK = 32'h0000_0010;

  localparam logic [7:0] RTSR_QUEUE_EMPTY = 8'h40;
  localparam int         RTSR_BIT_MORE    = 7;
  localparam int         RTSR_BIT_OVF     = 5;
  localparam int         RTSR_BIT_TOUCH   = 4;
  localparam int         RTSR_DEPTH       = 8;
  localparam int         RTSR_AW          = 3;

  localparam logic [1:0] RTSR_FAULT_NONE = 2'h0;
  localparam logic [1:0] RTSR_FAULT_VDD  = 2'h1;
  localparam logic [1:0] RTSR_FAULT_VSS  = 2'h2;

  localparam logic [1:0] RTSR_IRQ_RESET  = 2'h0;
  localparam logic [1:0] RTSR_MASK_RESET = 2'h0;

  typedef enum logic [1:0]
  {
    RTSR_PH_IDLE = 2'b00,
    RTSR_PH_DATA = 2'b01
  } rtsr_phase_e;

  typedef struct packed
  {
    logic       valid;
    logic [4:0] code;
  } rtsr_event_s;

  typedef struct packed
  {
    logic [1:0] code;
    logic       valid;
  } rtsr_fault_s;

endpackage

// file: rtsr_top.sv
// rotary touch status registers behind an ahb-lite slave
//
// What this block does
// R1 - queue entries carry bit 4 set and a 4-bit clockwise position index
// R2 - any host access to the device drops the host interrupt at once
// R3 - after clearing, interrupt returns only once the queue was emptied by reads
// R4 - fault register low bits: 00 none, 01 short to supply, 10 to ground
// R5 - fault register bits above the code read zero
// R6 - host writes only zero bytes to the fault register
// R7 - live position register reads zero in top three bits, code below
// R8 - writes to the live position register change nothing
// R9 - live position reads zero when released or rotary disabled
// R10 - touched live position reads bit 4 set plus the clockwise index
// R11 - entry bit 7 set while more entries follow, clear on the last
// R12 - on overflow newest events dropped, bit 5 flagged until last read
// R13 - read of an empty queue returns only bit six set
// R14 - a write to the queue register empties it, data ignored
// R15 - each queue read pops the returned entry
// R16 - fault code follows the most recent short detector result
`timescale 1ns/10ps
`default_nettype none
module rtsr_top
  import rtsr_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 ce,
  input  wire logic                 hsel,
  input  wire logic [31:0]          haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [31:0]          hwdata,
  input  wire logic                 hready,
  output logic      [31:0]          hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire rtsr_pkg::rtsr_event_s push,
  input  wire logic                 rotary_en,
  input  wire logic                 touched,
  input  wire logic [3:0]           position,
  input  wire rtsr_pkg::rtsr_fault_s fault_in,
  output logic                      host_irq,
  output logic                      irq
);
  import rtsr_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed
  {
    rtsr_phase_e        ph;
    logic               wr;
    logic [31:0]        addr;
    logic [RTSR_AW-1:0] rp;
    logic [RTSR_AW:0]   cnt;
    logic               ovf;
    logic               irq_armed;
    logic               host_irq;
    logic [1:0]         fault;
    logic [1:0]         ist;
    logic [1:0]         imask;
    logic [31:0]        rdata;
    logic               rd_pend;
  } rtsr_state_s;

  rtsr_state_s s_q;
  rtsr_state_s s_d;

  logic               push_ok;
  logic               pop;
  logic [RTSR_AW-1:0] wp;
  logic [3:0]         mem_rd;
  logic [RTSR_AW-1:0] raddr;
  logic               access;
  logic [31:0]        wd;

  assign access = hsel && hready && htrans[1];
  assign wp     = s_q.rp + s_q.cnt[RTSR_AW-1:0];
  // dropped once full, newest lost
  assign push_ok = push.valid && (s_q.cnt != (RTSR_AW+1)'(RTSR_DEPTH)); // R12
  assign pop     = s_q.ph == RTSR_PH_DATA && !s_q.wr && s_q.addr == RTSR_OFS_QUEUE
                   && s_q.cnt != '0; // R15
  assign raddr   = pop ? s_q.rp + RTSR_AW'(1) : s_q.rp;
  assign wd      = hwdata;

  rtsr_mem u_mem
  (
    .clk   (clk),
    .ce    (ce),
    .we    (push_ok),
    .waddr (wp),
    .wdata (push.code[3:0]),
    .raddr (raddr),
    .rdata (mem_rd)
  );

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    logic [1:0] ev;
    ev  = 2'h0;
    s_d = s_q;
    s_d.rd_pend = 1'b0;
    if (fault_in.valid)
      s_d.fault = fault_in.code; // R16
    // bus data phase
    if (s_q.ph == RTSR_PH_DATA && s_q.wr)
    begin
      unique case (s_q.addr)
        RTSR_OFS_QUEUE:
        begin
          s_d.cnt = '0; // R14
          s_d.ovf = 1'b0;
        end
        RTSR_OFS_IRQST: s_d.ist = s_q.ist & ~wd[1:0];
        RTSR_OFS_IRQMK: s_d.imask = wd[1:0];
        default: ; // R8
      endcase
    end
    if (pop)
    begin
      s_d.rp  = s_q.rp + RTSR_AW'(1);
      s_d.cnt = s_q.cnt - (RTSR_AW+1)'(1);
      if (s_q.cnt == (RTSR_AW+1)'(1))
      begin
        s_d.ovf       = 1'b0; // R12
        s_d.irq_armed = 1'b1; // R3
      end
    end
    if (push_ok && !(s_q.ph == RTSR_PH_DATA && s_q.wr && s_q.addr == RTSR_OFS_QUEUE))
      s_d.cnt = s_d.cnt + (RTSR_AW+1)'(1);
    if (push.valid && !push_ok)
    begin
      s_d.ovf = 1'b1; // R12
      ev[1]   = 1'b1;
    end
    if (push_ok)
      ev[0] = 1'b1;
    if (push_ok && s_q.irq_armed)
      s_d.host_irq = 1'b1;
    if (access)
    begin
      s_d.host_irq = 1'b0; // R2
      // an empty queue stays armed, else no event could ever interrupt again
      if (s_d.cnt != '0)
        s_d.irq_armed = 1'b0; // R3
    end
    if (pop && s_q.cnt == (RTSR_AW+1)'(1))
      s_d.irq_armed = 1'b1; // R3
    s_d.ist = s_d.ist | ev;
    // address phase capture
    if (access)
    begin
      s_d.ph   = RTSR_PH_DATA;
      s_d.wr   = hwrite;
      s_d.addr = {haddr[31:2], 2'b00};
    end
    else if (s_q.ph == RTSR_PH_DATA)
      s_d.ph = RTSR_PH_IDLE;
    // read data, a queue read only sets rd_pend here, entry assembled later
    s_d.rdata = 32'h0000_0000;
    if (access && !hwrite)
    begin
      unique case ({haddr[31:2], 2'b00})
        RTSR_OFS_QUEUE: s_d.rd_pend = 1'b1;
        RTSR_OFS_FAULT: s_d.rdata = {30'h0, s_q.fault}; // R4 R5
        RTSR_OFS_LIVE:
          if (rotary_en && touched)
            s_d.rdata = {24'h0, 3'h0, 1'b1, position}; // R7 R10
          else
            s_d.rdata = 32'h0000_0000; // R9
        RTSR_OFS_IRQST: s_d.rdata = {30'h0, s_q.ist};
        RTSR_OFS_IRQMK: s_d.rdata = {30'h0, s_q.imask};
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s_q       <= '0;
      s_q.ph    <= RTSR_PH_IDLE;
      s_q.irq_armed <= 1'b1;
      s_q.fault <= RTSR_FAULT_NONE;
      s_q.ist   <= RTSR_IRQ_RESET;
      s_q.imask <= RTSR_MASK_RESET;
    end
    else if (ce)
      s_q <= s_d;
  end

  // queue read byte built in data phase from registered memory output
  logic [7:0] qbyte;
  always_comb
  begin
    if (s_q.cnt == '0)
      qbyte = RTSR_QUEUE_EMPTY; // R13
    else
    begin
      qbyte = 8'h00;
      qbyte[RTSR_BIT_MORE]  = s_q.cnt > (RTSR_AW+1)'(1); // R11
      qbyte[RTSR_BIT_OVF]   = s_q.ovf; // R12
      qbyte[RTSR_BIT_TOUCH] = 1'b1; // R1
      qbyte[3:0]            = mem_rd; // R1
    end
  end

  assign hrdata    = s_q.rd_pend ? {24'h0, qbyte} : s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign host_irq  = s_q.host_irq;
  assign irq       = |(s_q.ist & s_q.imask);

  //////////////////////////////////////////////////////////////////////////////
  // checks

  sequence access_s;
    ce && access;
  endsequence

  // data phase of a read that hands out a stored entry
  sequence entry_rd_s;
    s_q.rd_pend && s_q.cnt != '0;
  endsequence

  // event offered while every slot is taken
  sequence full_push_s;
    ce && push.valid && s_q.cnt == (RTSR_AW+1)'(RTSR_DEPTH);
  endsequence

  // data phase of a write to the live position register
  sequence live_wr_s;
    ce && s_q.ph == RTSR_PH_DATA && s_q.wr && s_q.addr == RTSR_OFS_LIVE
      && !push.valid && !access;
  endsequence

  // interrupt lines
  irq_drop_a: assert property (@(posedge clk) disable iff (sys_rst) // R2
    access_s
    |=> !host_irq) else $error("host irq not cleared by access");
  irq_rearm_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (ce && !s_q.irq_armed && !access && !(pop && s_q.cnt == 1)) |=> !$rose(host_irq))
    else $error("host irq rose without queue drained");
  irq_set_a: assert property (@(posedge clk) disable iff (sys_rst) // R3
    (ce && push.valid && s_q.irq_armed && s_q.cnt != (RTSR_AW+1)'(RTSR_DEPTH) && !access)
    |=> host_irq) else $error("armed event raised no host irq");
  ist_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (ce && push.valid && s_q.cnt != (RTSR_AW+1)'(RTSR_DEPTH))
    |=> s_q.ist[0]) else $error("event status not set");

  // fault, live position and idle read data
  fault_hi_a: assert property (@(posedge clk) disable iff (sys_rst) // R5
    (s_q.ph == RTSR_PH_DATA && s_q.addr == RTSR_OFS_FAULT && !s_q.rd_pend)
    |-> hrdata[31:2] == 30'h0) else $error("fault upper bits set");
  fault_follow_a: assert property (@(posedge clk) disable iff (sys_rst) // R16
    (ce && fault_in.valid) |=> s_q.fault == $past(fault_in.code))
    else $error("fault code not captured");
  live_zero_a: assert property (@(posedge clk) disable iff (sys_rst) // R9
    (access_s and (!hwrite && {haddr[31:2], 2'b00} == RTSR_OFS_LIVE && !(rotary_en && touched)))
    |=> hrdata == 32'h0) else $error("live position not zero");
  live_code_a: assert property (@(posedge clk) disable iff (sys_rst) // R10
    (access_s and (!hwrite && {haddr[31:2], 2'b00} == RTSR_OFS_LIVE && rotary_en && touched))
    |=> hrdata == {27'h0, 1'b1, $past(position)}) else $error("live position wrong");
  live_wr_a: assert property (@(posedge clk) disable iff (sys_rst) // R8
    live_wr_s |=> $stable(s_q.cnt) && $stable(s_q.rp) && $stable(s_q.ovf) && $stable(s_q.ist)
    && $stable(s_q.imask)) else $error("live position write changed state");
  rd_idle_a: assert property (@(posedge clk) disable iff (sys_rst)
    (s_q.ph == RTSR_PH_IDLE)
    |-> hrdata == 32'h0) else $error("read data left standing");

  // queue
  empty_read_a: assert property (@(posedge clk) disable iff (sys_rst) // R13
    (s_q.rd_pend && s_q.cnt == 0)
    |-> hrdata == 32'h40) else $error("empty read wrong");
  clear_write_a: assert property (@(posedge clk) disable iff (sys_rst) // R14
    (ce && s_q.ph == RTSR_PH_DATA && s_q.wr && s_q.addr == RTSR_OFS_QUEUE && !push.valid)
    |=> s_q.cnt == 0) else $error("queue not emptied by write");
  more_flag_a: assert property (@(posedge clk) disable iff (sys_rst) // R11
    entry_rd_s
    |-> hrdata[7] == (s_q.cnt > 1) && hrdata[4]) else $error("more flag or touch bit wrong");
  entry_frame_a: assert property (@(posedge clk) disable iff (sys_rst) // R1
    entry_rd_s
    |-> hrdata[31:8] == 24'h0 && !hrdata[6]) else $error("queue entry framing wrong");
  ovf_set_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
    full_push_s
    |=> s_q.ovf && s_q.ist[1]) else $error("overflow not flagged");
  full_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
    (full_push_s and (!pop && !(s_q.ph == RTSR_PH_DATA && s_q.wr)))
    |=> s_q.cnt == (RTSR_AW+1)'(RTSR_DEPTH)) else $error("dropped event still stored");
  ovf_clear_a: assert property (@(posedge clk) disable iff (sys_rst) // R12
    (ce && pop && s_q.cnt == 1 && !push.valid)
    |=> !s_q.ovf) else $error("overflow kept after last read");
  pop_a: assert property (@(posedge clk) disable iff (sys_rst) // R15
    (ce && pop && !push.valid) |=> s_q.cnt == $past(s_q.cnt) - 1)
    else $error("read did not pop");
endmodule // rtsr_top
`default_nettype wire

// file: tb_top.sv
// self-checking bench for the rotary touch status registers
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rtsr_pkg::*;
  logic        clk = 1'h0;
  logic        sys_rst = 1'h1;
  logic        req = 1'h0;
  logic        wr = 1'h0;
  logic [31:0] addr = '0;
  logic [31:0] wdata = '0;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        hwrite, hreadyout, hresp, done, host_irq, irq;
  rtsr_event_s push = '0;
  rtsr_fault_s fault_in = '0;
  logic        rotary_en = 1'h0;
  logic        touched = 1'h0;
  logic [3:0]  position = '0;
  logic [31:0] seed = 32'hCDA4;
  logic [31:0] exp_q[$];
  logic [3:0]  p[$];
  logic [1:0]  fc[3] = '{RTSR_FAULT_VDD, RTSR_FAULT_VSS, RTSR_FAULT_NONE};
  int          n_fail = 0;
  int          comparisons = 0;
  rtsr_top i_rtsr_top (.clk(clk), .sys_rst(sys_rst), .ce(1'h1), .hsel(1'h1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .push(push), .rotary_en(rotary_en),
    .touched(touched), .position(position), .fault_in(fault_in), .host_irq(host_irq), .irq(irq));
  rtsr_host_model i_rtsr_host_model (.clk(clk), .sys_rst(sys_rst), .req(req), .addr(addr),
    .wr(wr), .wdata(wdata), .hrdata(hrdata), .hready(hreadyout), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rdata(rdata), .done(done));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic summarize();
    if (n_fail == 0 && comparisons > 0 && exp_q.size() == 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_fail++;
      $display("Error at %0t: read %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_irq(input logic eh, input logic ei);
    @(negedge clk);
    comparisons++;
    if (host_irq !== eh || irq !== ei)
    begin
      n_fail++;
      $display("Error at %0t: interrupt levels %b %b", $time, host_irq, irq);
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wr <= w;
    wdata <= d;
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (done !== 1'h1 && n < 20);
    if (done !== 1'h1)
    begin
      n_fail++;
      $display("Error at %0t: bus transfer timed out", $time);
      summarize();
    end
    else
      @(posedge clk);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'h0, '0);
  endtask
  task automatic ev();
    logic [3:0] v;
    v = 4'(rnd());
    p.push_back(v);
    @(posedge clk);
    push <= '{valid: 1'h1, code: {1'h1, v}};
    @(posedge clk);
    push <= '0;
  endtask
  task automatic pops(input logic ovf, input logic tail);
    logic [3:0] v;
    while (p.size() > 0)
    begin
      v = p.pop_front();
      rd(RTSR_OFS_QUEUE, {24'h0, p.size() != 0, 1'h0, ovf, 1'h1, v});
    end
    if (tail)
      rd(RTSR_OFS_QUEUE, {24'h0, RTSR_QUEUE_EMPTY});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk)
  begin
    if (done === 1'h1 && hwrite === 1'h0)
      chk(exp_q.pop_front(), rdata);
    if (done === 1'h1)
      chk(32'h0, {31'h0, hresp});
  end
  initial
  begin
    forever #20 clk = ~clk;
  end
  initial
  begin
    #(40 * 5000);
    n_fail++;
    summarize();
  end
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'h0;
    repeat (3) ev();
    chk_irq(1'h1, 1'h0);
    bus(RTSR_OFS_IRQMK, 1'h1, 32'h3);
    chk_irq(1'h0, 1'h1);
    ev();
    chk_irq(1'h0, 1'h1);
    pops(1'h0, 1'h0);
    ev();
    chk_irq(1'h1, 1'h1);
    bus(RTSR_OFS_IRQST, 1'h1, 32'h1);
    chk_irq(1'h0, 1'h0);
    // ninth push into a full queue is dropped
    repeat (8) ev();
    void'(p.pop_back());
    pops(1'h1, 1'h1);
    rd(RTSR_OFS_IRQST, 32'h3);
    rd(RTSR_OFS_IRQMK, 32'h3);
    bus(RTSR_OFS_IRQST, 1'h1, 32'h3);
    rd(RTSR_OFS_IRQST, 32'h0);
    chk_irq(1'h0, 1'h0);
    repeat (2) ev();
    chk_irq(1'h1, 1'h1);
    p.delete();
    bus(RTSR_OFS_QUEUE, 1'h1, 32'hFF);
    rd(RTSR_OFS_QUEUE, {24'h0, RTSR_QUEUE_EMPTY});
    for (int i = 0; i < 3; i++)
    begin
      @(posedge clk);
      fault_in <= '{code: fc[i], valid: 1'h1};
      @(posedge clk);
      fault_in <= '0;
      bus(RTSR_OFS_FAULT, 1'h1, 32'h0);
      rd(RTSR_OFS_FAULT, {30'h0, fc[i]});
    end
    rotary_en <= 1'h1;
    touched <= 1'h1;
    for (int i = 0; i < 16; i++)
    begin
      position <= 4'(i);
      rd(RTSR_OFS_LIVE, {24'h0, 4'h1, 4'(i)});
    end
    bus(RTSR_OFS_LIVE, 1'h1, 32'hFF);
    rd(RTSR_OFS_LIVE, 32'h1F);
    touched <= 1'h0;
    rd(RTSR_OFS_LIVE, 32'h0);
    touched <= 1'h1;
    rotary_en <= 1'h0;
    rd(RTSR_OFS_LIVE, 32'h0);
    rd(32'h0000_0020, 32'h0);
    summarize();
  end
endmodule // tb_top
`default_nettype wire
